// [lmfo_pkg.sv]
// lmfo_pkg: constants and types for the line mode and fault override control
package lmfo_pkg;

	// ------------------------------------------------------------
	// primary line modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		LMFO_FWD_BATT  = 3'h0,
		LMFO_REV_BATT  = 3'h1,
		LMFO_SCAN      = 3'h2,
		LMFO_RINGING   = 3'h3,
		LMFO_DISCON    = 3'h4,
		LMFO_TIP_AMP   = 3'h5,
		LMFO_RING_AMP  = 3'h6,
		LMFO_TR_AMP    = 3'h7
	} lmfo_mode_t;

	// ------------------------------------------------------------
	// secondary selection codes
	// ------------------------------------------------------------
	localparam logic [3:0] LMFO_SEC_METER_ON = 4'he;
	localparam logic [3:0] LMFO_SEC_ALL_OFF  = 4'hf;
	localparam logic [3:0] LMFO_SEC_VREF     = 4'hc;
	localparam int         LMFO_SEC_TEST_BIT = 3;

	// ------------------------------------------------------------
	// control states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LMFO_RUN   = 2'b01,
		LMFO_FAULT = 2'b10
	} lmfo_state_t;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam lmfo_mode_t LMFO_RESET_MODE = LMFO_DISCON;
	localparam logic [3:0] LMFO_RESET_SEC  = LMFO_SEC_ALL_OFF;
	localparam logic       LMFO_HOOK_ON    = 1'b1;
	localparam logic       LMFO_HOOK_OFF   = 1'b0;
	localparam int         LMFO_CLK_PS     = 5000;
	localparam int         LMFO_FILTER_NS  = 100;
	localparam int         LMFO_FILTER_CYC = (LMFO_FILTER_NS * 1000 + LMFO_CLK_PS - 1) / LMFO_CLK_PS;

endpackage : lmfo_pkg

// [lmfo_fault_if.sv]
// lmfo_fault_if: raw and qualified fault level between controller and filter
`timescale 1ns/1ps
`default_nettype none
interface lmfo_fault_if;
	logic raw;
	logic active;

	modport ctrl (output raw, input active);
	modport qual (input raw, output active);
endinterface : lmfo_fault_if
`default_nettype wire

// [lmfo_fault_qual.sv]
// lmfo_fault_qual: debounce filter for one fault monitor level
`timescale 1ns/1ps
`default_nettype none
module lmfo_fault_qual
	import lmfo_pkg::*;
#(
	parameter int FILTER_CYCLES = LMFO_FILTER_CYC
) (
	// clock and reset
	input  wire logic  clock,
	input  wire logic  rst,
	// fault level
	lmfo_fault_if.qual flt
);

	localparam int CW = $clog2(FILTER_CYCLES + 1);

	logic          active_q;
	logic          active_d;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;

	// ------------------------------------------------------------
	// filter: a level must hold steady before it is believed
	// ------------------------------------------------------------
	// short monitor chatter would otherwise toggle the line in and out of all-off
	always_comb begin
		active_d = active_q;
		count_d  = '0;
		if (flt.raw != active_q) begin
			if (count_q == CW'(FILTER_CYCLES - 1)) begin
				active_d = flt.raw;
			end else begin
				count_d = count_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			active_q <= 1'b0;
			count_q  <= '0;
		end else begin
			active_q <= active_d;
			count_q  <= count_d;
		end
	end

	assign flt.active = active_q;

endmodule : lmfo_fault_qual
`default_nettype wire

// [lmfo_ctrl.sv]
// lmfo_ctrl: line mode, metering/test path and fault override control
`timescale 1ns/1ps
`default_nettype none
module lmfo_ctrl
	import lmfo_pkg::*;
#(
	parameter int FILTER_CYCLES = LMFO_FILTER_CYC
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// mode selection pins
	input  wire lmfo_mode_t  primaryMode,
	input  wire logic [3:0]  secondaryMode,
	// supervision detectors
	input  wire logic        loopClosed,
	input  wire logic        ringTrip,
	// fault monitors
	input  wire logic        thermalFault,
	input  wire logic        batteryHigh,
	input  wire logic        batteryLow,
	// line mode applied
	output lmfo_mode_t       lineMode,
	output logic             allOff,
	output logic             faultActive,
	// metering path
	output logic             meteringPulseInputEn,
	output logic             meteringPulseOutputOe,
	// test path
	output logic             testSignalInputEn,
	output logic             testLevelOutputOe,
	// supervision
	output logic             hookStatusOut
);

	// ------------------------------------------------------------
	// fault qualification
	// ------------------------------------------------------------
	lmfo_fault_if thermIf ();
	lmfo_fault_if battIf ();

	assign thermIf.raw = thermalFault;
	assign battIf.raw  = batteryHigh | batteryLow;

	lmfo_fault_qual #(
		.FILTER_CYCLES (FILTER_CYCLES)
	) uThermQual (
		.clock (clock),
		.rst   (rst),
		.flt   (thermIf.qual)
	);

	lmfo_fault_qual #(
		.FILTER_CYCLES (FILTER_CYCLES)
	) uBattQual (
		.clock (clock),
		.rst   (rst),
		.flt   (battIf.qual)
	);

	logic faultNow;

	assign faultNow = thermIf.active | battIf.active;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic killsMeter(input lmfo_mode_t m);
		killsMeter = (m == LMFO_SCAN) || (m == LMFO_DISCON) || (m == LMFO_RINGING);
	endfunction : killsMeter

	function automatic logic isTestCode(input logic [3:0] s);
		isTestCode = s[LMFO_SEC_TEST_BIT] && (s != LMFO_SEC_METER_ON) && (s != LMFO_SEC_ALL_OFF);
	endfunction : isTestCode

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	lmfo_state_t state_q;
	lmfo_state_t state_d;
	lmfo_mode_t  mode_q;
	lmfo_mode_t  mode_d;
	lmfo_mode_t  lastPrim_q;
	lmfo_mode_t  lastPrim_d;
	logic [3:0]  lastSec_q;
	logic [3:0]  lastSec_d;
	logic [3:0]  sec_q;
	logic [3:0]  sec_d;
	logic        meter_q;
	logic        meter_d;
	lmfo_mode_t  savedMode_q;
	lmfo_mode_t  savedMode_d;
	logic [3:0]  savedSec_q;
	logic [3:0]  savedSec_d;
	logic        savedMeter_q;
	logic        savedMeter_d;
	logic        primChange;
	logic        secChange;

	// pin levels are remembered in every state, so that a selection made during
	// a fault does not take effect at recovery; the saved state comes back instead
	always_comb begin
		state_d      = state_q;
		mode_d       = mode_q;
		sec_d        = sec_q;
		meter_d      = meter_q;
		savedMode_d  = savedMode_q;
		savedSec_d   = savedSec_q;
		savedMeter_d = savedMeter_q;
		lastPrim_d   = primaryMode;
		lastSec_d    = secondaryMode;
		primChange   = (primaryMode != lastPrim_q);
		secChange    = (secondaryMode != lastSec_q);
		case (state_q)
			LMFO_RUN: begin
				if (faultNow) begin
					// snapshot only on first entry; a second fault joins the hold
					state_d      = LMFO_FAULT;
					savedMode_d  = mode_q;
					savedSec_d   = sec_q;
					savedMeter_d = meter_q;
				end else begin
					if (primChange) begin
						mode_d = primaryMode;
						if (killsMeter(primaryMode)) begin
							meter_d = 1'b0;
						end
						// other modes leave the metering latch untouched
					end
					if (secChange) begin
						sec_d = secondaryMode;
						if (secondaryMode == LMFO_SEC_METER_ON) begin
							meter_d = !killsMeter(primaryMode);
						end else begin
							meter_d = 1'b0;
						end
					end
				end
			end
			LMFO_FAULT: begin
				if (!faultNow) begin
					// leave only when both monitors are clear
					state_d = LMFO_RUN;
					mode_d  = savedMode_q;
					sec_d   = savedSec_q;
					meter_d = savedMeter_q;
				end
			end
			default: begin
				state_d = LMFO_RUN;
				mode_d  = LMFO_RESET_MODE;
				sec_d   = LMFO_RESET_SEC;
				meter_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q      <= LMFO_RUN;
			mode_q       <= LMFO_RESET_MODE;
			sec_q        <= LMFO_RESET_SEC;
			meter_q      <= 1'b0;
			lastPrim_q   <= LMFO_RESET_MODE;
			lastSec_q    <= LMFO_RESET_SEC;
			savedMode_q  <= LMFO_RESET_MODE;
			savedSec_q   <= LMFO_RESET_SEC;
			savedMeter_q <= 1'b0;
		end else begin
			state_q      <= state_d;
			mode_q       <= mode_d;
			sec_q        <= sec_d;
			meter_q      <= meter_d;
			lastPrim_q   <= lastPrim_d;
			lastSec_q    <= lastSec_d;
			savedMode_q  <= savedMode_d;
			savedSec_q   <= savedSec_d;
			savedMeter_q <= savedMeter_d;
		end
	end

	// ------------------------------------------------------------
	// output decode
	// ------------------------------------------------------------
	lmfo_mode_t lineMode_d;
	logic       allOff_d;
	logic       meterIn_d;
	logic       meterOe_d;
	logic       testIn_d;
	logic       testOe_d;
	logic       hook_d;

	// outputs follow the next state so they change on the same edge as it;
	// the detectors pass through one register, a cycle of latency on hook status
	always_comb begin
		lineMode_d = mode_d;
		allOff_d   = (state_d == LMFO_FAULT);
		meterIn_d  = 1'b0;
		meterOe_d  = 1'b0;
		testIn_d   = 1'b0;
		testOe_d   = 1'b0;
		hook_d     = LMFO_HOOK_ON;
		if (state_d == LMFO_FAULT) begin
			// all paths off; line mode output still shows the held mode
			hook_d = LMFO_HOOK_OFF;
		end else begin
			meterIn_d = meter_d;
			meterOe_d = meter_d;
			testOe_d  = isTestCode(sec_d);
			testIn_d  = isTestCode(sec_d) && (sec_d != LMFO_SEC_VREF);
			case (mode_d)
				LMFO_DISCON: begin
					hook_d = LMFO_HOOK_ON;
				end
				LMFO_RINGING: begin
					hook_d = ringTrip ? LMFO_HOOK_OFF : LMFO_HOOK_ON;
				end
				default: begin
					hook_d = loopClosed ? LMFO_HOOK_OFF : LMFO_HOOK_ON;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lineMode              <= LMFO_RESET_MODE;
			allOff                <= 1'b0;
			faultActive           <= 1'b0;
			meteringPulseInputEn  <= 1'b0;
			meteringPulseOutputOe <= 1'b0;
			testSignalInputEn     <= 1'b0;
			testLevelOutputOe     <= 1'b0;
			hookStatusOut         <= LMFO_HOOK_ON;
		end else begin
			lineMode              <= lineMode_d;
			allOff                <= allOff_d;
			faultActive           <= allOff_d;
			meteringPulseInputEn  <= meterIn_d;
			meteringPulseOutputOe <= meterOe_d;
			testSignalInputEn     <= testIn_d;
			testLevelOutputOe     <= testOe_d;
			hookStatusOut         <= hook_d;
		end
	end

endmodule : lmfo_ctrl
`default_nettype wire

// [lmfo_ctrl_asserts.sv]
// lmfo_ctrl_asserts: port checks for lmfo_ctrl
`timescale 1ns/1ps
`default_nettype none
module lmfo_ctrl_asserts
	import lmfo_pkg::*;
(
	// --------------------------------
	// clock and reset
	// --------------------------------
	input wire logic	clock,
	input wire logic	rst,
	// --------------------------------
	// pins and monitors
	// --------------------------------
	input wire lmfo_mode_t	primaryMode,
	input wire logic [3:0]	secondaryMode,
	input wire logic	thermalFault,
	input wire logic	batteryHigh,
	input wire logic	batteryLow,
	// --------------------------------
	// outputs
	// --------------------------------
	input wire lmfo_mode_t	lineMode,
	input wire logic	allOff,
	input wire logic	faultActive,
	input wire logic	meteringPulseInputEn,
	input wire logic	meteringPulseOutputOe,
	input wire logic	testSignalInputEn,
	input wire logic	testLevelOutputOe,
	input wire logic	hookStatusOut
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// raw low means no fault can qualify at the next edge
	wire logic raw = thermalFault | batteryHigh | batteryLow;
	wire logic paths = meteringPulseInputEn | meteringPulseOutputOe | testSignalInputEn
		| testLevelOutputOe;
	wire logic calm = !allOff && !raw;
	property p_off; allOff |-> !paths && !hookStatusOut; endproperty
	a_off: assert property (p_off) else $error("fault left path or hook");
	property p_flag; faultActive == allOff; endproperty
	a_flag: assert property (p_flag) else $error("fault flags differ");
	property p_sec; (calm && secondaryMode == 4'hf && $changed(secondaryMode)) |=> !paths; endproperty
	a_sec: assert property (p_sec) else $error("off code left path");
	// a fault qualifying from the previous raw level wins over a pin change
	property p_mon; (calm && !$past(raw) && secondaryMode == LMFO_SEC_METER_ON
		&& $changed(secondaryMode) && primaryMode == LMFO_FWD_BATT)
		|=> meteringPulseInputEn && meteringPulseOutputOe; endproperty
	a_mon: assert property (p_mon) else $error("metering not on");
	property p_mdrop; (meteringPulseInputEn && $changed(primaryMode) && primaryMode inside
		{LMFO_SCAN, LMFO_DISCON, LMFO_RINGING}) |=> !meteringPulseInputEn; endproperty
	a_mdrop: assert property (p_mdrop) else $error("metering kept");
	property p_mkeep; (meteringPulseInputEn && !raw && !$past(raw) && secondaryMode == LMFO_SEC_METER_ON
		&& primaryMode inside {LMFO_FWD_BATT, LMFO_REV_BATT, LMFO_TIP_AMP, LMFO_RING_AMP})
		|=> meteringPulseInputEn; endproperty
	a_mkeep: assert property (p_mkeep) else $error("metering dropped");
	property p_follow; (calm && !$past(raw) && $changed(primaryMode))
		|=> lineMode == $past(primaryMode); endproperty
	a_follow: assert property (p_follow) else $error("line mode not applied");
	property p_dhook; (!allOff && !$past(allOff) && lineMode == LMFO_DISCON && $stable(lineMode))
		|-> hookStatusOut; endproperty
	a_dhook: assert property (p_dhook) else $error("disconnect hook low");
	c_meter: cover property ($rose(meteringPulseInputEn));
	c_fault: cover property ($rose(allOff));
	c_back: cover property ($fell(allOff) && meteringPulseInputEn);
endmodule : lmfo_ctrl_asserts
bind lmfo_ctrl lmfo_ctrl_asserts chk_u (.clock, .rst, .primaryMode, .secondaryMode,
	.thermalFault, .batteryHigh, .batteryLow, .lineMode, .allOff, .faultActive,
	.meteringPulseInputEn, .meteringPulseOutputOe, .testSignalInputEn, .testLevelOutputOe,
	.hookStatusOut);
`default_nettype wire

// [lmfo_line_model.sv]
// lmfo_line_model: loop and thermal detectors on the line side
`timescale 1ns/1ps
`default_nettype none
module lmfo_line_model (
	// commands
	input wire logic	clock,
	input wire logic	offHook,
	input wire logic	trip,
	input wire logic	hot,
	// detector levels
	output var logic	loopClosed,
	output var logic	ringTrip,
	output var logic	thermalFault
);
	// levels settle just after the edge, like a slow analog detector
	initial {loopClosed, ringTrip, thermalFault} = 3'h0;
	always @(posedge clock) begin
		loopClosed <= #1 offHook;
		ringTrip <= #1 trip;
		thermalFault <= #1 hot;
	end
endmodule : lmfo_line_model
`default_nettype wire

// [tb_top.sv]
// tb_top: self-checking bench for lmfo_ctrl
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lmfo_pkg::*;
	logic		clock, rst, offHook, trip, hot, batteryHigh, batteryLow;
	logic		loopClosed, ringTrip, thermalFault, allOff, mIn, mOut, tIn, tOut, hook;
	logic		faultAct;
	lmfo_mode_t	primaryMode, lineMode;
	logic [3:0]	secondaryMode;
	int		errorCnt = 0;
	int		totalChecks = 0;
	lmfo_mode_t	keep[3] = '{LMFO_REV_BATT, LMFO_TIP_AMP, LMFO_RING_AMP};
	lmfo_mode_t	drop[3] = '{LMFO_SCAN, LMFO_RINGING, LMFO_DISCON};
	// short filter keeps fault runs brief
	lmfo_ctrl #(.FILTER_CYCLES(2)) dut_u (.clock, .rst, .primaryMode, .secondaryMode,
		.loopClosed, .ringTrip, .thermalFault, .batteryHigh, .batteryLow, .lineMode,
		.allOff, .faultActive(faultAct), .meteringPulseInputEn(mIn), .meteringPulseOutputOe(mOut),
		.testSignalInputEn(tIn), .testLevelOutputOe(tOut), .hookStatusOut(hook));
	lmfo_line_model line_u (.clock, .offHook, .trip, .hot, .loopClosed, .ringTrip,
		.thermalFault);
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic chk_bit(input string what, input logic exp, input logic got);
		totalChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic chk_mode(input lmfo_mode_t exp);
		totalChecks++;
		if (lineMode !== exp) begin
			errorCnt++;
			$display("ERROR lineMode expected %0d seen %0d", exp, lineMode);
		end
	endtask : chk_mode
	task automatic pins(input lmfo_mode_t p, input logic [3:0] s);
		primaryMode = p;
		secondaryMode = s;
		step(1);
	endtask : pins
	task automatic closeOut;
		$display("checks %0d mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : closeOut
	// bounded wait on the shutdown flag; running out ends the run
	task automatic wait_off(input logic v);
		for (int i = 0; i < 40 && allOff !== v; i++) step(1);
		chk_bit("allOff", v, allOff);
		chk_bit("faultActive", v, faultAct);
		if (allOff !== v) closeOut();
	endtask : wait_off
	task automatic t_meter;
		pins(LMFO_FWD_BATT, LMFO_SEC_METER_ON);
		chk_bit("meterIn", 1, mIn);
		chk_bit("meterOut", 1, mOut);
		foreach (keep[i]) begin
			pins(keep[i], LMFO_SEC_METER_ON);
			chk_bit("meterIn", 1, mIn);
			chk_mode(keep[i]);
		end
		foreach (drop[i]) begin
			pins(LMFO_FWD_BATT, LMFO_SEC_ALL_OFF);
			pins(LMFO_FWD_BATT, LMFO_SEC_METER_ON);
			pins(drop[i], LMFO_SEC_METER_ON);
			chk_bit("meterIn", 0, mIn);
			chk_mode(drop[i]);
		end
		$display("test meter done");
	endtask : t_meter
	task automatic t_off;
		pins(LMFO_REV_BATT, 4'h8);
		chk_bit("testIn", 1, tIn);
		chk_bit("testOut", 1, tOut);
		pins(LMFO_REV_BATT, LMFO_SEC_VREF);
		chk_bit("testIn", 0, tIn);
		chk_bit("testOut", 1, tOut);
		pins(LMFO_REV_BATT, LMFO_SEC_ALL_OFF);
		chk_bit("testIn", 0, tIn);
		chk_bit("testOut", 0, tOut);
		chk_mode(LMFO_REV_BATT);
		pins(LMFO_REV_BATT, LMFO_SEC_METER_ON);
		pins(LMFO_REV_BATT, LMFO_SEC_ALL_OFF);
		chk_bit("meterIn", 0, mIn);
		chk_bit("meterOut", 0, mOut);
		$display("test off done");
	endtask : t_off
	task automatic t_fault;
		pins(LMFO_FWD_BATT, LMFO_SEC_METER_ON);
		hot = 1;
		wait_off(1);
		chk_bit("hook", 0, hook);
		chk_bit("meterIn", 0, mIn);
		pins(LMFO_SCAN, LMFO_SEC_ALL_OFF);
		batteryLow = 1;
		step(4);
		hot = 0;
		step(8);
		chk_bit("allOff", 1, allOff);
		batteryLow = 0;
		wait_off(0);
		chk_bit("meterIn", 1, mIn);
		chk_mode(LMFO_FWD_BATT);
		pins(LMFO_DISCON, LMFO_SEC_ALL_OFF);
		batteryHigh = 1;
		wait_off(1);
		chk_bit("hook", 0, hook);
		batteryHigh = 0;
		wait_off(0);
		step(2);
		chk_bit("hook", 1, hook);
		pins(LMFO_REV_BATT, LMFO_SEC_METER_ON);
		hot = 1;
		wait_off(1);
		hot = 0;
		wait_off(0);
		chk_bit("meterIn", 1, mIn);
		chk_mode(LMFO_REV_BATT);
		$display("test fault done");
	endtask : t_fault
	task automatic t_hook;
		pins(LMFO_FWD_BATT, LMFO_SEC_ALL_OFF);
		offHook = 1;
		step(3);
		chk_bit("hook", 0, hook);
		offHook = 0;
		pins(LMFO_RINGING, LMFO_SEC_ALL_OFF);
		step(2);
		chk_bit("hook", 1, hook);
		trip = 1;
		step(3);
		chk_bit("hook", 0, hook);
		$display("test hook done");
	endtask : t_hook
	initial begin
		rst = 1;
		{offHook, trip, hot, batteryHigh, batteryLow} = 5'h00;
		primaryMode = LMFO_DISCON;
		secondaryMode = LMFO_SEC_ALL_OFF;
		repeat (12) @(posedge clock);
		#1 rst = 0;
		step(1);
		chk_mode(LMFO_DISCON);
		chk_bit("hook", 1, hook);
		$display("test reset done");
		t_meter();
		t_off();
		t_fault();
		t_hook();
		closeOut();
	end
endmodule : tb_top
`default_nettype wire
